// file: emp_pulse_out.sv
// Functional notes
// - The fault output goes high when the two current channels differ by more than 6.25 percent.
// - The fault output also goes high when current flows but no voltage is seen (missing neutral).
// - The fault output is not latched and drops as soon as neither condition is detected.
// - The reverse power output goes high when average active power is negative.
// - The reverse power output clears again once active power is positive.
// - The reverse power output changes only at the moment a calibration pulse is issued.
// - The calibration output gives active high pulses at a rate that follows instantaneous power.
// - The two low-rate outputs carry average power and can drive a counter or stepper directly.
// - The two rate select inputs pick one of four power to frequency scalings.
// - The calibration rate select input picks the scaling of the calibration output.
// - In missing neutral the power of all outputs is scaled by the missing neutral cal level.
// - Low-rate pulses are 120 ms high unless the output rate is too high for that.
// - Calibration pulses are 90 ms high unless the output rate is too high for that.
// - The b output falls half an output period after the a output, so the two alternate.
// - Between a pulse on one low-rate output and one on the other lie at least four clocks.
`timescale 1ns/100ps
module emp_pulse_out #(
  parameter int unsigned F_PULSE_CYC  = emp_pkg::F_PULSE_CYC,
  parameter int unsigned CF_PULSE_CYC = emp_pkg::CF_PULSE_CYC
) (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // channel samples
  input  wire logic                        sample_valid_i,
  input  wire logic [emp_pkg::SAMPLE_W-1:0] phase_current_input_i,
  input  wire logic [emp_pkg::SAMPLE_W-1:0] neutral_current_input_i,
  input  wire logic [emp_pkg::SAMPLE_W-1:0] line_voltage_input_i,
  input  wire logic [emp_pkg::SAMPLE_W-1:0] missing_neutral_cal_input_i,
  // static selects
  input  wire logic                        rate_select_hi_i,
  input  wire logic                        rate_select_lo_i,
  input  wire logic                        cal_rate_select_i,
  // pulse and indicator outputs
  output logic                             calibration_pulse_output_o,
  output logic                             low_rate_pulse_a_o,
  output logic                             low_rate_pulse_b_o,
  output logic                             fault_o,
  output logic                             reverse_power_output_o
);
  import emp_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [WIN_W-1:0]         win_cnt_reg;
  logic [SUM_W-1:0]         sum_a_reg, sum_b_reg, sum_v_reg;
  logic [SUM_W-1:0]         sum_a_next, sum_b_next, sum_v_next;
  logic [SUM_W-1:0]         big_sum, small_sum;
  logic                     mism_reg, miss_reg, sel_b_reg, fault_reg;
  logic [SAMPLE_W-1:0]      abs_a, abs_b, abs_v, abs_sel;
  logic signed [SAMPLE_W-1:0] i_sel;
  logic signed [PWR_W-1:0]  prod;
  logic [PWR_W-1:0]         pmag_reg;
  logic                     pneg_reg, pvld_reg;
  logic signed [ACC_W-1:0]  avg_reg, p_signed;
  logic [ACC_W-1:0]         avg_mag;
  logic [ACC_W-1:0]         cf_acc_reg, cf_sum, cf_thr;
  logic [ACC_W-1:0]         f_acc_reg, f_sum, f_thr;
  logic                     cf_fire, f_fire, turn_b_reg, rev_reg;
  logic [2:0]               quiet_reg;
  logic                     cf_pulse, a_pulse, b_pulse;

  function automatic logic [SAMPLE_W-1:0] mag16(input logic [SAMPLE_W-1:0] s);
    mag16 = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : s;
  endfunction

  // ----------------------------------------------------------------
  // fault and missing neutral detection
  // ----------------------------------------------------------------
  // magnitude sums over one window
  always_comb begin
    abs_a      = mag16(phase_current_input_i);
    abs_b      = mag16(neutral_current_input_i);
    abs_v      = mag16(line_voltage_input_i);
    sum_a_next = sum_a_reg + SUM_W'(abs_a);
    sum_b_next = sum_b_reg + SUM_W'(abs_b);
    sum_v_next = sum_v_reg + SUM_W'(abs_v);
    big_sum    = (sum_a_next >= sum_b_next) ? sum_a_next : sum_b_next;
    small_sum  = (sum_a_next >= sum_b_next) ? sum_b_next : sum_a_next;
  end

  // window counter and sums
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_cnt_reg <= '0;
      sum_a_reg   <= '0;
      sum_b_reg   <= '0;
      sum_v_reg   <= '0;
    end else if (sample_valid_i) begin
      win_cnt_reg <= win_cnt_reg + 1'b1;
      if (win_cnt_reg == WIN_LAST) begin
        sum_a_reg <= '0;
        sum_b_reg <= '0;
        sum_v_reg <= '0;
      end else begin
        sum_a_reg <= sum_a_next;
        sum_b_reg <= sum_b_next;
        sum_v_reg <= sum_v_next;
      end
    end
  end

  // conditions re-judged every window, never held past it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mism_reg  <= 1'b0;
      miss_reg  <= 1'b0;
      sel_b_reg <= 1'b0;
    end else if (sample_valid_i && win_cnt_reg == WIN_LAST) begin
      mism_reg  <= (big_sum >= CUR_MIN_SUM) && ((big_sum - small_sum) > (big_sum >> MISMATCH_SHFT));
      miss_reg  <= (big_sum >= CUR_MIN_SUM) && (sum_v_next < VOLT_MIN_SUM);
      sel_b_reg <= (sum_b_next > sum_a_next);                                                         // bill larger
    end
  end

  // fault output flop follows both conditions
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= mism_reg | miss_reg;
    end
  end

  // ----------------------------------------------------------------
  // power computation
  // ----------------------------------------------------------------
  always_comb begin
    i_sel   = sel_b_reg ? neutral_current_input_i : phase_current_input_i;
    abs_sel = mag16(i_sel);
    prod    = $signed(line_voltage_input_i) * i_sel;
  end

  // instantaneous power magnitude and sign
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pmag_reg <= '0;
      pneg_reg <= 1'b0;
      pvld_reg <= 1'b0;
    end else begin
      pvld_reg <= sample_valid_i;
      if (sample_valid_i) begin
        if (miss_reg) begin
          pmag_reg <= PWR_W'(abs_sel) * PWR_W'(missing_neutral_cal_input_i);
          pneg_reg <= 1'b0;
        end else begin
          pmag_reg <= prod[PWR_W-1] ? PWR_W'(-prod) : PWR_W'(prod);
          pneg_reg <= prod[PWR_W-1];
        end
      end
    end
  end

  // average power low pass
  always_comb begin
    p_signed = pneg_reg ? -$signed({8'h00, pmag_reg}) : $signed({8'h00, pmag_reg});
    avg_mag  = avg_reg[ACC_W-1] ? ACC_W'(-avg_reg) : ACC_W'(avg_reg);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avg_reg <= '0;
    end else if (pvld_reg) begin
      avg_reg <= avg_reg + ((p_signed - avg_reg) >>> AVG_SHIFT);
    end
  end

  // ----------------------------------------------------------------
  // digital to frequency conversion
  // ----------------------------------------------------------------
  always_comb begin
    f_thr   = F_THR[{rate_select_hi_i, rate_select_lo_i}];
    cf_thr  = cal_rate_select_i ? (f_thr >> CF_SHIFT_HI) : (f_thr >> CF_SHIFT_LO);
    cf_sum  = cf_acc_reg + (pvld_reg ? ACC_W'(pmag_reg) : '0);
    cf_fire = (cf_sum >= cf_thr);
    f_sum   = f_acc_reg + (pvld_reg ? avg_mag : '0);
    f_fire  = (f_sum >= f_thr) && (quiet_reg == 3'(MIN_GAP_CYC));
  end

  // energy accumulators; a held-off low-rate fire stays pending
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cf_acc_reg <= '0;
      f_acc_reg  <= '0;
    end else begin
      cf_acc_reg <= cf_fire ? cf_sum - cf_thr : cf_sum;
      f_acc_reg  <= f_fire ? f_sum - f_thr : f_sum;
    end
  end

  // quiet time since either low-rate output was high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_reg <= 3'(MIN_GAP_CYC);
    end else if (a_pulse || b_pulse || f_fire) begin
      quiet_reg <= '0;
    end else if (quiet_reg != 3'(MIN_GAP_CYC)) begin
      quiet_reg <= quiet_reg + 1'b1;
    end
  end

  // phase alternation between a and b
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      turn_b_reg <= 1'b0;
    end else if (f_fire) begin
      turn_b_reg <= ~turn_b_reg;
    end
  end

  // reverse indicator sampled only with a calibration pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rev_reg <= 1'b0;
    end else if (cf_fire) begin
      rev_reg <= avg_reg[ACC_W-1];
    end
  end

  // ----------------------------------------------------------------
  // pulse shapers
  // ----------------------------------------------------------------
  emp_pulse_gen #(.GAP(0)) u_cf_gen (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .fire_i  (cf_fire),
    .width_i (CNT_W'(CF_PULSE_CYC)),
    .pulse_o (cf_pulse)
  );

  emp_pulse_gen #(.GAP(MIN_GAP_CYC)) u_a_gen (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .fire_i  (f_fire && !turn_b_reg),
    .width_i (CNT_W'(F_PULSE_CYC)),
    .pulse_o (a_pulse)
  );

  emp_pulse_gen #(.GAP(MIN_GAP_CYC)) u_b_gen (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .fire_i  (f_fire && turn_b_reg),
    .width_i (CNT_W'(F_PULSE_CYC)),
    .pulse_o (b_pulse)
  );

  // output assignments
  assign calibration_pulse_output_o = cf_pulse;
  assign low_rate_pulse_a_o         = a_pulse;
  assign low_rate_pulse_b_o         = b_pulse;
  assign fault_o                    = fault_reg;
  assign reverse_power_output_o     = rev_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [CNT_W-1:0] cf_hi_cnt_reg, a_hi_cnt_reg, other_idle_reg;
  logic             last_b_reg;

  // helper counters for pulse widths, quiet time and order
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cf_hi_cnt_reg  <= '0;
      a_hi_cnt_reg   <= '0;
      other_idle_reg <= '0;
      last_b_reg     <= 1'b1;
    end else begin
      cf_hi_cnt_reg  <= cf_pulse ? cf_hi_cnt_reg + 1'b1 : '0;
      a_hi_cnt_reg   <= a_pulse ? a_hi_cnt_reg + 1'b1 : '0;
      other_idle_reg <= b_pulse ? '0 : ((other_idle_reg != '1) ? other_idle_reg + 1'b1 : other_idle_reg);
      if (a_pulse && !$past(a_pulse)) begin
        last_b_reg <= 1'b0;
      end else if (b_pulse && !$past(b_pulse)) begin
        last_b_reg <= 1'b1;
      end
    end
  end

  sequence window_end_s;
    sample_valid_i && win_cnt_reg == WIN_LAST;
  endsequence

  sequence clear_conditions_s;
    !mism_reg && !miss_reg;
  endsequence

  fault_level_a: assert property (window_end_s ##1 (mism_reg || miss_reg) |=> fault_o)
    else $error("fault output missed a detected condition");
  fault_clear_a: assert property (clear_conditions_s [*2] |-> !fault_o)
    else $error("fault output held after conditions cleared");
  rev_hold_a: assert property ($changed(reverse_power_output_o) |-> $rose(calibration_pulse_output_o))
    else $error("reverse output changed between calibration pulses");
  rev_sign_a: assert property ($rose(calibration_pulse_output_o) |-> reverse_power_output_o == $past(avg_reg[ACC_W-1]))
    else $error("reverse output does not follow power sign");
  cf_width_a: assert property (calibration_pulse_output_o |-> cf_hi_cnt_reg < CNT_W'(CF_PULSE_CYC))
    else $error("calibration pulse longer than its width");
  f_width_a: assert property (low_rate_pulse_a_o |-> a_hi_cnt_reg < CNT_W'(F_PULSE_CYC))
    else $error("low rate pulse longer than its width");
  f_gap_a: assert property ($rose(low_rate_pulse_a_o) |-> $past(other_idle_reg) >= CNT_W'(MIN_GAP_CYC))
    else $error("low rate pulses closer than four clocks");
  f_alt_a: assert property ($rose(low_rate_pulse_a_o) |-> $past(last_b_reg))
    else $error("low rate outputs did not alternate");
  miss_scale_a: assert property (sample_valid_i && miss_reg |=>
    pmag_reg == PWR_W'($past(abs_sel)) * PWR_W'($past(missing_neutral_cal_input_i)))
    else $error("missing neutral power not scaled by cal level");

endmodule

// file: emp_pkg.sv
package emp_pkg;

  // ----------------------------------------------------------------
  // clock and pulse timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ      = 125000;                   // 125 MHz core clock
  localparam int unsigned F_PULSE_MS   = 120;                      // low-rate pulse high time
  localparam int unsigned CF_PULSE_MS  = 90;                       // calibration pulse high time
  localparam int unsigned F_PULSE_CYC  = F_PULSE_MS * CLK_KHZ;
  localparam int unsigned CF_PULSE_CYC = CF_PULSE_MS * CLK_KHZ;
  localparam int unsigned MIN_GAP_CYC  = 4;                        // least quiet time between a and b

  // ----------------------------------------------------------------
  // datapath widths
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned SUM_W    = 24;
  localparam int unsigned PWR_W    = 32;
  localparam int unsigned ACC_W    = 40;
  localparam int unsigned CNT_W    = 32;
  localparam int unsigned WIN_W    = 8;

  // ----------------------------------------------------------------
  // fault and missing neutral detection
  // ----------------------------------------------------------------
  localparam logic [WIN_W-1:0] WIN_LAST      = 8'hFF;              // 256 samples per window
  localparam int unsigned      MISMATCH_SHFT = 4;                  // 1/16 = 6.25 percent
  localparam logic [SUM_W-1:0] CUR_MIN_SUM   = 24'h00_1000;        // current noise floor
  localparam logic [SUM_W-1:0] VOLT_MIN_SUM  = 24'h00_1000;        // voltage present level

  // ----------------------------------------------------------------
  // digital to frequency scaling
  // ----------------------------------------------------------------
  localparam int unsigned AVG_SHIFT   = 8;                         // average power filter
  localparam int unsigned CF_SHIFT_LO = 4;                         // cal select low: cf = 16 x f
  localparam int unsigned CF_SHIFT_HI = 6;                         // cal select high: cf = 64 x f
  localparam logic [3:0][ACC_W-1:0] F_THR = {
    40'h00_1000_0000,                                              // select 3
    40'h00_2000_0000,                                              // select 2
    40'h00_4000_0000,                                              // select 1
    40'h00_8000_0000                                               // select 0
  };

endpackage

// file: emp_pulse_gen.sv
`timescale 1ns/100ps
module emp_pulse_gen #(
  parameter int unsigned GAP = 0
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // trigger and width
  input  wire logic                     fire_i,
  input  wire logic [emp_pkg::CNT_W-1:0] width_i,
  // pulse out
  output logic                          pulse_o
);
  import emp_pkg::*;

  logic [CNT_W-1:0] period_cnt_reg;
  logic [CNT_W-1:0] high_cnt_reg;
  logic             pulse_reg;
  logic [CNT_W-1:0] half_per;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] len_next;

  // width shrinks to fit the trigger period at high rates
  always_comb begin
    half_per = period_cnt_reg >> 1;
    limit    = (half_per > CNT_W'(GAP)) ? half_per - CNT_W'(GAP) : {{(CNT_W-1){1'b0}}, 1'b1};
    len_next = (width_i < limit) ? width_i : limit;
    if (len_next == '0) begin
      len_next = {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // cycles since the previous trigger, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_cnt_reg <= '1;
    end else if (fire_i) begin
      period_cnt_reg <= '0;
    end else if (period_cnt_reg != '1) begin
      period_cnt_reg <= period_cnt_reg + 1'b1;
    end
  end

  // high time counter and output flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_cnt_reg <= '0;
      pulse_reg    <= 1'b0;
    end else if (fire_i) begin
      high_cnt_reg <= len_next;
      pulse_reg    <= 1'b1;
    end else begin
      pulse_reg <= (high_cnt_reg > {{(CNT_W-1){1'b0}}, 1'b1});
      if (high_cnt_reg != '0) begin
        high_cnt_reg <= high_cnt_reg - 1'b1;
      end
    end
  end

  assign pulse_o = pulse_reg;

endmodule

// file: emp_stepper_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// two-phase stepper or counter on the low-rate pulse pair
// ----------------------------------------------------------------
module emp_stepper_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // low-rate pulse pair
  input  wire logic        pulse_a_i,
  input  wire logic        pulse_b_i,
  // step count and phase faults
  output logic [15:0]      step_cnt_o,
  output logic [15:0]      phase_err_o
);
  logic a_reg;
  logic b_reg;
  logic last_b_reg;

  // one step per rising edge, phases expected a then b in turn
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_reg       <= 1'b0;
      b_reg       <= 1'b0;
      last_b_reg  <= 1'b1;             // first step is due on a
      step_cnt_o  <= 16'h0000;
      phase_err_o <= 16'h0000;
    end else begin
      a_reg <= pulse_a_i;
      b_reg <= pulse_b_i;
      if ((pulse_a_i && !a_reg) || (pulse_b_i && !b_reg)) begin
        step_cnt_o <= step_cnt_o + 16'h0001;
      end
      if (pulse_a_i && !a_reg) begin
        last_b_reg <= 1'b0;
        if (!last_b_reg) phase_err_o <= phase_err_o + 16'h0001;
      end
      if (pulse_b_i && !b_reg) begin
        last_b_reg <= 1'b1;
        if (last_b_reg) phase_err_o <= phase_err_o + 16'h0001;
      end
    end
  end
endmodule

// file: emp_pulse_out_tb.sv
`timescale 1ns/100ps
module emp_pulse_out_tb;
  import emp_pkg::*;
  localparam int unsigned FP  = 20;    // shortened low-rate width
  localparam int unsigned CP  = 15;    // shortened cal width
  localparam logic [31:0] YES = 32'h0000_0001;
  typedef struct packed {
    logic [15:0] ph, ne, vo, cal;
    logic [2:0]  sel;                  // {hi, lo, cal select}
    logic        flt;
  } emp_row_type;
  // ----------------------------------------------------------------
  // ordinary cases: cf count over 4096 cycles and fault level
  // ----------------------------------------------------------------
  localparam emp_row_type ROWS [0:10] = '{
    '{16'h1000, 16'h1000, 16'h0100, 16'h0000, 3'b000, 1'b0},
    '{16'h1000, 16'h1000, 16'h0100, 16'h0000, 3'b010, 1'b0},
    '{16'h1000, 16'h1000, 16'h0100, 16'h0000, 3'b100, 1'b0},
    '{16'h1000, 16'h1000, 16'h0100, 16'h0000, 3'b110, 1'b0},
    '{16'h1000, 16'h1000, 16'h0100, 16'h0000, 3'b001, 1'b0},
    '{16'h1000, 16'h0E66, 16'h0100, 16'h0000, 3'b000, 1'b1},
    '{16'h1000, 16'h0F33, 16'h0100, 16'h0000, 3'b000, 1'b0},
    '{16'h1000, 16'h1000, 16'h0000, 16'h0200, 3'b000, 1'b1},
    '{16'h1000, 16'h1000, 16'h0000, 16'h0100, 3'b000, 1'b1},
    '{16'h0E66, 16'h1000, 16'h0100, 16'h0000, 3'b000, 1'b1},
    '{16'h1000, 16'h1000, 16'h0100, 16'h0000, 3'b000, 1'b0}};
  localparam emp_row_type BASE = '{16'h1000, 16'h1000, 16'h0800, 16'h0000, 3'b000, 1'b0};

  logic        clk_i, rst_n_i, sv, hi, lo, cal_rate_select;
  logic [15:0] ph, ne, vo, cal;
  logic        cf, fa, fb, flt, rev;
  logic [15:0] steps, perr;
  int unsigned num_errors, tests_run, cf_cnt, cyc, step_base;
  int unsigned cf_len, a_len, b_len, quiet, a_fall, b_fall, d_ab;
  logic        cf_q, a_q, b_q, rev_q, steady;

  emp_pulse_out #(.F_PULSE_CYC(FP), .CF_PULSE_CYC(CP)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sample_valid_i(sv),
    .phase_current_input_i(ph), .neutral_current_input_i(ne),
    .line_voltage_input_i(vo), .missing_neutral_cal_input_i(cal),
    .rate_select_hi_i(hi), .rate_select_lo_i(lo), .cal_rate_select_i(cal_rate_select),
    .calibration_pulse_output_o(cf), .low_rate_pulse_a_o(fa), .low_rate_pulse_b_o(fb),
    .fault_o(flt), .reverse_power_output_o(rev));
  emp_stepper_model motor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pulse_a_i(fa), .pulse_b_i(fb),
    .step_cnt_o(steps), .phase_err_o(perr));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] near(int unsigned a, int unsigned b, int unsigned t);
    return (((a > b) ? a - b : b - a) <= t) ? YES : 32'h0000_0000;
  endfunction
  // expected cal pulses in 4096 cycles from power and scaling
  function automatic int unsigned exp_cf(emp_row_type r);
    longint unsigned i, v, thr;
    i   = (r.ph > r.ne) ? r.ph : r.ne;
    v   = (r.vo == 16'h0000) ? r.cal : r.vo;
    thr = F_THR[r.sel[2:1]] >> (r.sel[0] ? CF_SHIFT_HI : CF_SHIFT_LO);
    return int'((64'd4096 * i * v) / thr);
  endfunction
  task automatic apply(emp_row_type r);
    @(posedge clk_i);
    ph <= r.ph;
    ne <= r.ne;
    vo <= r.vo;
    cal <= r.cal;
    {hi, lo, cal_rate_select} <= r.sel;
  endtask
  task automatic outs_zero();
    @(negedge clk_i);
    check({27'h000_0000, cf, fa, fb, flt, rev}, 32'h0000_0000);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // output monitor: widths, gaps, alternation and indicator timing
  always @(negedge clk_i) begin
    if (!rst_n_i) begin
      {cf_q, a_q, b_q, rev_q} = 4'h0;
      {cf_len, a_len, b_len, quiet} = {32'd0, 32'd0, 32'd0, 32'd8};
    end else begin
      cyc++;
      if (cf && !cf_q) cf_cnt++;
      if (!cf && cf_q) check(YES, (cf_len <= CP) ? YES : 32'h0000_0000);
      if (!fa && a_q) check(a_len, FP);
      if (!fb && b_q) check(b_len, FP);
      if ((fa && !a_q) || (fb && !b_q)) check(YES, (quiet >= MIN_GAP_CYC) ? YES : 32'h0000_0000);
      if (rev !== rev_q) check({31'h0, cf && !cf_q}, YES);
      if (!fb && b_q) d_ab = cyc - a_fall;
      if (!fa && a_q && steady) check(near(d_ab, cyc - b_fall, 2), YES);
      if (!fa && a_q) a_fall = cyc;
      if (!fb && b_q) b_fall = cyc;
      cf_len = cf ? cf_len + 1 : 0;
      a_len  = fa ? a_len + 1 : 0;
      b_len  = fb ? b_len + 1 : 0;
      quiet  = (fa || fb) ? 0 : quiet + 1;
      {cf_q, a_q, b_q, rev_q} = {cf, fa, fb, rev};
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, sv, hi, lo, cal_rate_select, steady} = 6'h00;
    {ph, ne, vo, cal} = 64'h0;
    {num_errors, tests_run, cf_cnt, cyc, d_ab, a_fall, b_fall} = 0;
    repeat (6) @(posedge clk_i);
    outs_zero();
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    outs_zero();
    @(posedge clk_i);
    sv <= 1'b1;
    // ordinary cases
    foreach (ROWS[n]) begin
      apply(ROWS[n]);
      repeat (1024) @(posedge clk_i);
      cf_cnt = 0;
      repeat (4096) @(posedge clk_i);
      check(near(cf_cnt, exp_cf(ROWS[n]), 1), YES);
      check({31'h0, flt}, {31'h0, ROWS[n].flt});
    end
    // low-rate pair under steady power, then a select change mid-run
    apply(BASE);
    repeat (2048) @(posedge clk_i);
    step_base = steps;
    steady = 1'b1;
    repeat (4096) @(posedge clk_i);
    steady = 1'b0;
    check(near(steps - step_base, 16, 2), YES);
    check({16'h0, perr}, 32'h0000_0000);
    @(posedge clk_i);
    lo <= 1'b1;
    repeat (1024) @(posedge clk_i); // widths stay whole across the change
    // reverse power sets and clears with cal pulses
    apply('{16'h1000, 16'h1000, 16'hF800, 16'h0000, 3'b000, 1'b0});
    repeat (4096) @(posedge clk_i);
    check({31'h0, rev}, YES);
    apply(BASE);
    repeat (4096) @(posedge clk_i);
    check({31'h0, rev}, 32'h0000_0000);
    // reset in mid-run while pulses are active
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    outs_zero();
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    outs_zero();
    cf_cnt = 0;
    repeat (1024) @(posedge clk_i);
    // power 0x80_0000 per cycle against threshold 0x800_0000: one pulse per 16 cycles
    check(near(cf_cnt, 64, 2), YES);
    wrap_up();
  end
endmodule
